// *** rtl/bod_core.sv ***
// Purpose: executes bit-set, test-skip and a few side-effect instructions
// Assumes: AHB-Lite slave, single word transfers, one clock hclk
// Notes: each transfer takes at least one wait state
`default_nettype none

module bod_core
    import bod_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe
);

    // bus state
    bod_bus_e bus_state, next_bus_state;
    logic [7:0] dph_addr, next_dph_addr;
    logic dph_write, next_dph_write;
    logic dph_ok, next_dph_ok;
    logic [31:0] next_hrdata;
    logic next_hreadyout;

    // core state
    bod_ex_e ex_state, next_ex_state;
    logic [11:0] instr, next_instr;
    logic [7:0] acc, next_acc;
    logic [10:0] pc, next_pc;
    logic presc_to_wdt, next_presc_to_wdt;
    logic skip_pending, next_skip_pending;
    logic zero_flag, next_zero_flag;
    logic [7:0] prescaler, next_prescaler;
    logic [7:0] drive_en, next_drive_en;
    logic [7:0] port_latch, next_port_latch;
    logic [15:0] cycles, next_cycles;

    // file ram port
    logic ram_we;
    logic [4:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;

    // decode of the held instruction
    logic is_set, is_test, is_move, is_dir, is_jump;
    logic [4:0] op_f;
    logic [2:0] op_b;
    logic op_d;
    logic [7:0] bit_mask;
    logic [7:0] operand;
    logic [7:0] result;
    logic exec_write;
    logic [31:0] reg_rdata;
    logic bus_take;
    logic dph_file;

    bod_file_ram u_ram (
        .clk(hclk),
        .rst_n(hresetn),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // field decode; set and test leave the zero flag alone, test may set skip_pending
    assign is_set = instr[11:8] == OPC_SET_BIT;
    assign is_test = instr[11:8] == OPC_TEST_CLR;
    assign is_move = instr[11:6] == OPC_MOVE_FILE;
    assign is_dir = instr[11:3] == OPC_LOAD_DIR;
    assign is_jump = instr[11:9] == OPC_JUMP;
    assign op_f = instr[4:0];
    assign op_b = instr[7:5];
    assign op_d = instr[5];
    assign bit_mask = 8'h01 << op_b;

    // port operand comes from the pins, not the latch
    always_comb begin
        if (op_f == FILE_PORT) begin
            operand = port_pin_in;
        end else if (op_f == FILE_PCL) begin
            operand = pc[7:0];
        end else begin
            operand = ram_rdata;
        end
    end

    // write-back value and whether the instruction writes a file
    assign result = is_set ? (operand | bit_mask) : operand;
    assign exec_write = (ex_state == EX_EXEC) &&
        (is_set || (is_move && op_d));

    // address phase qualifiers
    assign bus_take = (bus_state == BS_IDLE) && hsel && hready && htrans[1];
    assign dph_file = dph_addr[FILE_WIN_BIT];

    // register read mux, bits above each field read zero
    always_comb begin
        reg_rdata = 32'h0000_0000;
        if (dph_addr == OFS_INSTR) begin
            reg_rdata[11:0] = instr;
        end else if (dph_addr == OFS_ACC) begin
            reg_rdata[7:0] = acc;
        end else if (dph_addr == OFS_PC) begin
            reg_rdata[10:0] = pc;
        end else if (dph_addr == OFS_CTRL) begin
            reg_rdata[CTRL_PRESC_WDT] = presc_to_wdt;
        end else if (dph_addr == OFS_STATUS) begin
            reg_rdata[ST_BUSY] = ex_state != EX_IDLE;
            reg_rdata[ST_SKIP] = skip_pending;
            reg_rdata[ST_ZERO] = zero_flag;
        end else if (dph_addr == OFS_PRESC) begin
            reg_rdata[7:0] = prescaler;
        end else if (dph_addr == OFS_DIR) begin
            reg_rdata[7:0] = ~drive_en;
        end else if (dph_addr == OFS_LATCH) begin
            reg_rdata[7:0] = port_latch;
        end else if (dph_addr == OFS_PINS) begin
            reg_rdata[7:0] = port_pin_in;
        end else if (dph_addr == OFS_CYCLES) begin
            reg_rdata[15:0] = cycles;
        end
    end

    // next state of the bus slave and the execution core together,
    // since both write pc, acc and the ram port
    always_comb begin
        next_bus_state = bus_state;
        next_dph_addr = dph_addr;
        next_dph_write = dph_write;
        next_dph_ok = dph_ok;
        next_hrdata = hrdata;
        next_hreadyout = hreadyout;
        next_ex_state = ex_state;
        next_instr = instr;
        next_acc = acc;
        next_pc = pc;
        next_presc_to_wdt = presc_to_wdt;
        next_skip_pending = skip_pending;
        next_zero_flag = zero_flag;
        next_drive_en = drive_en;
        next_port_latch = port_latch;
        next_cycles = cycles;
        ram_we = 1'b0;
        ram_addr = op_f;
        ram_wdata = result;
        // free running count, cleared below by timer writes while presc_to_wdt is 0
        next_prescaler = prescaler + 8'h01;

        // execution sequence: read operand, then execute in one slot
        unique case (ex_state)
            EX_IDLE: begin
            end
            EX_READ: begin
                next_ex_state = EX_EXEC;
            end
            EX_EXEC: begin
                next_ex_state = EX_IDLE;
                next_cycles = cycles + 16'h0001;
                next_pc = pc + 11'h001;
                if (is_test && !operand[op_b]) begin
                    next_skip_pending = 1'b1;
                end
                if (is_move) begin
                    next_zero_flag = operand == 8'h00;
                    if (!op_d) begin
                        next_acc = operand;
                    end
                end
                if (is_dir && instr[2:0] == DIR_PORT_SEL) begin
                    // stored as driver enables: one in acc is off
                    next_drive_en = ~acc;
                end
                if (is_jump) begin
                    // the jump alone loads bit 8 from its operand
                    next_pc = {pc[10:9], instr[8:0]};
                end
                if (exec_write) begin
                    if (op_f == FILE_PCL) begin
                        next_pc = {pc[10:9], 1'b0, result};
                    end else if (op_f == FILE_PORT) begin
                        next_port_latch = result;
                    end else begin
                        ram_we = 1'b1;
                    end
                    if (op_f == FILE_TIMER && !presc_to_wdt) begin
                        next_prescaler = 8'h00;
                    end
                end
            end
        endcase

        // bus slave: capture, wait for an idle core, then answer
        unique case (bus_state)
            BS_IDLE: begin
                if (bus_take) begin
                    next_bus_state = BS_WAIT;
                    next_hreadyout = 1'b0;
                    next_dph_addr = haddr[7:0];
                    next_dph_write = hwrite;
                    next_dph_ok = (haddr[31:8] == 24'h00_0000) &&
                        (hsize == HSIZE_WORD);
                end
            end
            BS_WAIT: begin
                // holding off while busy keeps the ram single owner
                if (ex_state == EX_IDLE) begin
                    next_bus_state = BS_IDLE;
                    next_hreadyout = 1'b1;
                    next_hrdata = 32'h0000_0000;
                    if (!dph_ok) begin
                        // unmapped or narrow: ignored, reads zero
                    end else if (dph_file) begin
                        ram_addr = dph_addr[6:2];
                        if (dph_write) begin
                            ram_we = 1'b1;
                            ram_wdata = hwdata[7:0];
                        end else begin
                            next_bus_state = BS_RAM;
                            next_hreadyout = 1'b0;
                            // last answer stands until the ram word lands
                            next_hrdata = hrdata;
                        end
                    end else if (!dph_write) begin
                        next_hrdata = reg_rdata;
                    end else if (dph_addr == OFS_INSTR) begin
                        next_instr = hwdata[11:0];
                        if (skip_pending) begin
                            // fetched word dropped, runs as a no-op
                            next_skip_pending = 1'b0;
                            next_pc = pc + 11'h001;
                            next_cycles = cycles + 16'h0001;
                        end else begin
                            next_ex_state = EX_READ;
                        end
                    end else if (dph_addr == OFS_ACC) begin
                        next_acc = hwdata[7:0];
                    end else if (dph_addr == OFS_PC) begin
                        next_pc = hwdata[10:0];
                    end else if (dph_addr == OFS_CTRL) begin
                        next_presc_to_wdt = hwdata[CTRL_PRESC_WDT];
                    end
                end
            end
            BS_RAM: begin
                next_bus_state = BS_IDLE;
                next_hreadyout = 1'b1;
                next_hrdata = {24'h00_0000, ram_rdata};
            end
        endcase
    end

    // all state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BS_IDLE;
            dph_addr <= 8'h00;
            dph_write <= 1'b0;
            dph_ok <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ex_state <= EX_IDLE;
            instr <= 12'h000;
            acc <= 8'h00;
            pc <= RST_PC;
            presc_to_wdt <= RST_PRESC_WDT;
            skip_pending <= 1'b0;
            zero_flag <= 1'b0;
            prescaler <= 8'h00;
            drive_en <= RST_DRIVE_EN;
            port_latch <= 8'h00;
            cycles <= 16'h0000;
            port_pin_out <= 8'h00;
            port_pin_oe <= RST_DRIVE_EN;
        end else begin
            bus_state <= next_bus_state;
            dph_addr <= next_dph_addr;
            dph_write <= next_dph_write;
            dph_ok <= next_dph_ok;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= 1'b0; // always OKAY
            ex_state <= next_ex_state;
            instr <= next_instr;
            acc <= next_acc;
            pc <= next_pc;
            presc_to_wdt <= next_presc_to_wdt;
            skip_pending <= next_skip_pending;
            zero_flag <= next_zero_flag;
            prescaler <= next_prescaler;
            drive_en <= next_drive_en;
            port_latch <= next_port_latch;
            cycles <= next_cycles;
            // pin copies load with the latches, from their next values
            port_pin_out <= next_port_latch;
            port_pin_oe <= next_drive_en;
        end
    end

endmodule // bod_core

`default_nettype wire

// *** rtl/bod_file_ram.sv ***
// Purpose: 32 x 8 general file register storage
// Assumes: one port, write and read in the same cycle allowed
// Notes: read data is registered, one cycle after the address
`default_nettype none

module bod_file_ram (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [32];
    logic [7:0] next_rdata;

    // old data on a same-cycle write, like a plain sync ram
    always_comb begin
        next_rdata = mem[addr];
    end

    // storage is not reset; only the read register is
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule // bod_file_ram

`default_nettype wire

// *** rtl/bod_pkg.sv ***
// Purpose: constants and types shared by the bit-op decode block
// Assumes: 12-bit instruction words, 8-bit file registers, 11-bit pc
// Notes: offsets below are AHB-Lite byte addresses, one word apart
`default_nettype none

package bod_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PRESC = 8'h14;
    localparam logic [7:0] OFS_DIR = 8'h18;
    localparam logic [7:0] OFS_LATCH = 8'h1C;
    localparam logic [7:0] OFS_PINS = 8'h20;
    localparam logic [7:0] OFS_CYCLES = 8'h24;
    localparam int FILE_WIN_BIT = 7;

    // field positions
    localparam int CTRL_PRESC_WDT = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_ZERO = 2;

    // reset values
    localparam logic RST_PRESC_WDT = 1'h1;
    localparam logic [7:0] RST_DRIVE_EN = 8'h00;
    localparam logic [10:0] RST_PC = 11'h7FF;

    // opcode prefixes
    localparam logic [3:0] OPC_SET_BIT = 4'h5;
    localparam logic [3:0] OPC_TEST_CLR = 4'h6;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
    localparam logic [8:0] OPC_LOAD_DIR = 9'h000;
    localparam logic [2:0] OPC_JUMP = 3'h5;

    // special file addresses and operands
    localparam logic [4:0] FILE_TIMER = 5'h01;
    localparam logic [4:0] FILE_PCL = 5'h02;
    localparam logic [4:0] FILE_PORT = 5'h06;
    localparam logic [2:0] DIR_PORT_SEL = 3'h6;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        BS_IDLE = 3'h1,
        BS_WAIT = 3'h2,
        BS_RAM = 3'h4
    } bod_bus_e;

    typedef enum logic [2:0] {
        EX_IDLE = 3'h1,
        EX_READ = 3'h2,
        EX_EXEC = 3'h4
    } bod_ex_e;

endpackage

`default_nettype wire

// *** testbench/bod_core_assertions.sv ***
// Purpose: port-level checks for bod_core
// Assumes: one clock hclk, async active-low hresetn
// Notes: write age bounds when instruction side effects may appear
`default_nettype none

module bod_core_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe
);
    logic [3:0] wr_age;
    logic bad_rd;
    wire logic taken = hsel && hready && htrans[1] && hreadyout;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // saturating age of the last write, so idle pins can be judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_age <= 4'hF;
            bad_rd <= 1'b0;
        end else begin
            if (taken && hwrite)
                wr_age <= 4'h0;
            else if (wr_age != 4'hF)
                wr_age <= wr_age + 4'h1;
            if (taken)
                bad_rd <= !hwrite && (haddr[31:8] != 24'h0);
        end
    end

    AST_RST_HIZ: assert property (
        $rose(hresetn) |-> port_pin_oe == 8'h00 && port_pin_out == 8'h00)
        else $error("pins driven right after reset");
    AST_OE_CAUSE: assert property (
        !$stable(port_pin_oe) |-> wr_age <= 4'hA)
        else $error("pin enables moved without an instruction");
    AST_OUT_CAUSE: assert property (
        !$stable(port_pin_out) |-> wr_age <= 4'hA)
        else $error("pin outputs moved without an instruction");
    AST_PINS_NO_DRIVE: assert property (
        $changed(port_pin_in) && wr_age > 4'hA |=> $stable(port_pin_out))
        else $error("pin levels leaked into the latch");
    AST_WAIT: assert property (taken |=> !hreadyout)
        else $error("transfer answered without a wait state");
    AST_ANSWER: assert property (taken |-> ##[1:8] hreadyout)
        else $error("transfer not answered in time");
    AST_UNMAPPED_ZERO: assert property (
        $rose(hreadyout) && bad_rd |-> hrdata == 32'h0)
        else $error("unmapped read returned data");
    AST_HRDATA_HOLD: assert property (
        !$rose(hreadyout) |-> $stable(hrdata) && !hresp)
        else $error("read data moved outside an answer");
endmodule // bod_core_assertions

bind bod_core bod_core_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe)
);

`default_nettype wire

// *** testbench/bod_core_tb_top.sv ***
// Purpose: directed bench for bod_core over AHB-Lite
// Assumes: single word transfers, hready tied to hreadyout
// Notes: every instruction is followed by a busy poll
`default_nettype none

module bod_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bod_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] port_pin_in, port_pin_out, port_pin_oe;
    int n_errors = 0;
    int n_checks = 0;
    wire logic hready = hreadyout;

    bod_core dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_pin_in(port_pin_in),
        .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe)
    );

    // 250 MHz
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task wrap_up;
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task hang;
        n_errors++;
        $display("Error at %0t: wait timed out", $time);
        wrap_up();
    endtask

    // bounded wait for hready at a rising edge
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1)
            hang();
    endtask

    // one single word transfer: address phase, then data phase
    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, {24'h0, o}, d, x);
    endtask

    task rd(input logic [7:0] o, output logic [31:0] d);
        bus(1'b0, {24'h0, o}, 32'h0, d);
    endtask

    // issue one word, then poll busy so results have landed
    task exec(input logic [11:0] op);
        logic [31:0] s;
        int n;
        wr(OFS_INSTR, {20'h0, op});
        n = 0;
        do begin
            rd(OFS_STATUS, s);
            n++;
        end while (s[ST_BUSY] !== 1'b0 && n < 20);
        if (s[ST_BUSY] !== 1'b0)
            hang();
    endtask

    task s_reset;
        logic [31:0] v;
        rd(OFS_DIR, v);
        chk(v, 32'hFF);
        chk({24'h0, port_pin_oe}, 32'h0);
        rd(OFS_PC, v);
        chk(v, {21'h0, RST_PC});
        bus(1'b0, 32'h100, 32'h0, v);
        chk(v, 32'h0);
    endtask

    // every bit index, zero flag untouched, cycle count up by one per set
    task s_set;
        logic [31:0] v, c0;
        wr(8'h90, 32'h0);
        exec(12'h204);
        wr(8'h8C, 32'h0A);
        exec({4'h5, 3'd7, 5'd3});
        rd(8'h8C, v);
        chk(v, 32'h8A);
        wr(8'h9C, 32'h0);
        rd(OFS_CYCLES, c0);
        for (int b = 0; b < 8; b++) begin
            exec({4'h5, b[2:0], 5'd7});
            rd(8'h9C, v);
            chk(v, (32'h2 << b) - 32'h1);
        end
        rd(OFS_CYCLES, v);
        chk(v, (c0 + 32'h8) & 32'hFFFF);
        rd(OFS_STATUS, v);
        chk({31'h0, v[ST_ZERO]}, 32'h1);
    endtask

    // clear bit skips the next word, set bit does not
    task s_skip;
        logic [31:0] v, p0, c0;
        wr(8'h94, 32'h04);
        rd(OFS_PC, p0);
        rd(OFS_CYCLES, c0);
        exec({4'h6, 3'd1, 5'd5});
        rd(OFS_STATUS, v);
        chk({31'h0, v[ST_SKIP]}, 32'h1);
        exec({4'h5, 3'd0, 5'd5});
        rd(8'h94, v);
        chk(v, 32'h04);
        rd(OFS_PC, v);
        chk(v, (p0 + 32'h2) & 32'h7FF);
        rd(OFS_CYCLES, v);
        chk(v, (c0 + 32'h2) & 32'hFFFF);
        exec({4'h6, 3'd2, 5'd5});
        exec({4'h5, 3'd0, 5'd5});
        rd(8'h94, v);
        chk(v, 32'h05);
        rd(OFS_STATUS, v);
        chk({31'h0, v[ST_ZERO]}, 32'h1);
    endtask

    // pc-low writes drop bit 8, the jump keeps its own
    task s_pc;
        logic [31:0] v;
        wr(OFS_PC, 32'h1AB);
        exec(12'h222);
        rd(OFS_PC, v);
        chk(v, 32'h0AB);
        wr(OFS_PC, 32'h1AB);
        exec({4'h5, 3'd6, 5'd2});
        rd(OFS_PC, v);
        chk(v, 32'h0EB);
        wr(OFS_PC, 32'h400);
        exec(12'hB03);
        rd(OFS_PC, v);
        chk(v, 32'h503);
    endtask

    // idle first so a pin change is seen far from any write
    task s_port;
        logic [31:0] v;
        repeat (16) @(posedge hclk);
        port_pin_in <= 8'h5A;
        wr(OFS_ACC, 32'hF0);
        exec(12'h006);
        chk({24'h0, port_pin_oe}, 32'h0F);
        rd(OFS_DIR, v);
        chk(v, 32'hF0);
        wr(OFS_ACC, 32'h0);
        exec(12'h005);
        chk({24'h0, port_pin_oe}, 32'h0F);
        exec({4'h5, 3'd0, 5'd6});
        chk({24'h0, port_pin_out}, 32'h5B);
        port_pin_in <= 8'h33;
        exec(12'h226);
        chk({24'h0, port_pin_out}, 32'h33);
    endtask

    // same timing twice; only the timer-owned run may clear
    task s_timer;
        logic [31:0] r0, r1;
        logic [7:0] e;
        wr(OFS_CTRL, 32'h1);
        rd(OFS_PRESC, r0);
        exec({4'h5, 3'd0, 5'd1});
        rd(OFS_PRESC, r1);
        e = r1[7:0] - r0[7:0];
        wr(OFS_CTRL, 32'h0);
        rd(OFS_PRESC, r0);
        exec({4'h5, 3'd0, 5'd1});
        rd(OFS_PRESC, r1);
        chk({31'h0, r1[7:0] < e}, 32'h1);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        port_pin_in = 8'h00;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_set();
        s_skip();
        s_pc();
        s_port();
        s_timer();
        wrap_up();
    end
endmodule // bod_core_tb_top

`default_nettype wire
